// ### hw/lbaa_pkg.sv
// Purpose: Constants for the leaky-bucket activity alarm, configuration 1
// Assumes: 100 MHz system clock
// Notes:   Register offsets are byte addresses on the serial register port
package lbaa_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] LBAA_SET_LEVEL_ADDR   = 8'h54;
  localparam logic [7:0] LBAA_CLEAR_LEVEL_ADDR = 8'h55;
  localparam logic [7:0] LBAA_DECAY_RATE_ADDR  = 8'h57;
  localparam logic [7:0] LBAA_SET_LEVEL_RST    = 8'h06;
  localparam logic [7:0] LBAA_CLEAR_LEVEL_RST  = 8'h04;
  localparam logic [1:0] LBAA_DECAY_RATE_RST   = 2'h1;
  localparam int         LBAA_DECAY_LSB        = 0;
  localparam int         LBAA_DECAY_MSB        = 1;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam longint LBAA_CLK_HZ        = 100000000;
  localparam longint LBAA_CYCLE_MS      = 128;
  localparam longint LBAA_CYCLE_CLOCKS  = (LBAA_CLK_HZ * LBAA_CYCLE_MS) / 1000;

  typedef enum logic [1:0] {
    LBAA_IDLE_TYPE_UNUSED,
    LBAA_RUN
  } lbaa_state_type;

endpackage : lbaa_pkg

// ### hw/lbaa_tick.sv
// Purpose: Observation cycle timebase, one pulse per 128 ms
// Assumes: Free-running system clock
// Notes:   Period is a parameter so simulation can shorten it
`timescale 1ns/1ps
module lbaa_tick
  import lbaa_pkg::*;
#(
  parameter int PERIOD = int'(LBAA_CYCLE_CLOCKS)
) (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  output logic      tick_out
);

  logic [31:0] count_r;

  // ----------------------------------------------------------------------
  // Cycle counter
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_r  <= 32'h0;
      tick_out <= 1'b0;
    end else if (count_r == 32'(PERIOD - 1)) begin
      count_r  <= 32'h0;
      tick_out <= 1'b1;  // [RQ1]
    end else begin
      count_r  <= count_r + 32'h1;
      tick_out <= 1'b0;
    end
  end

endmodule : lbaa_tick

// ### hw/lbaa_top.sv
// Purpose: Leaky-bucket inactivity alarm for one input clock, config set 1
// Assumes: Fault flags and register port are synchronous to CLOCK_IN
// Notes:   Bucket size limit is outside this block; the count saturates at 255
`timescale 1ns/1ps
// Behaviour
// RQ1 - Observe the input in 128 ms cycles; update the bucket once per cycle.
// RQ2 - A cycle with failure or erratic activity adds one to the bucket.
// RQ3 - Each clean period of 1, 2, 4 or 8 cycles takes one away.
// RQ4 - Raise the inactivity alarm when the bucket reaches the set level.
// RQ5 - Clear a raised alarm once the bucket drains to the clear level.
// RQ6 - Set and clear levels are independent 8-bit read/write registers.
// RQ7 - Decay codes 00..11 mean 128, 256, 512, 1024 ms; reset code 01.
// RQ8 - The bucket never goes below zero.
module lbaa_top
  import lbaa_pkg::*;
#(
  parameter int CYCLE_CLOCKS = int'(LBAA_CYCLE_CLOCKS)
) (
  input  wire logic       CLOCK_IN,
  input  wire logic       RST_N_IN,
  input  wire logic       FAULT_IN,
  input  wire logic       WR_EN_IN,
  input  wire logic       RD_EN_IN,
  input  wire logic [7:0] ADDR_IN,
  input  wire logic [7:0] WDATA_IN,
  output logic      [7:0] RDATA_OUT,
  output logic            ALARM_OUT,
  output logic      [7:0] BUCKET_OUT
);

  logic       tick;
  logic [7:0] set_level_r;
  logic [7:0] clear_level_r;
  logic [1:0] decay_rate_r;
  logic       fault_seen_r;
  logic [2:0] clean_count_r;
  logic [7:0] bucket_nxt;
  logic       alarm_nxt;
  logic [2:0] clean_limit;

  // ----------------------------------------------------------------------
  // Timebase
  // ----------------------------------------------------------------------
  lbaa_tick #(
    .PERIOD   (CYCLE_CLOCKS)
  ) u_tick (
    .clk_in   (CLOCK_IN),
    .rst_n_in (RST_N_IN),
    .tick_out (tick)
  );

  // Clean cycles per decrement, minus one
  function automatic logic [2:0] decay_limit(input logic [1:0] code);  // [RQ7]
    case (code)
      2'h0:    decay_limit = 3'h0;
      2'h1:    decay_limit = 3'h1;
      2'h2:    decay_limit = 3'h3;
      default: decay_limit = 3'h7;
    endcase
  endfunction : decay_limit

  // ----------------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------------
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      set_level_r   <= LBAA_SET_LEVEL_RST;
      clear_level_r <= LBAA_CLEAR_LEVEL_RST;
      decay_rate_r  <= LBAA_DECAY_RATE_RST;  // [RQ7]
    end else if (WR_EN_IN) begin
      case (ADDR_IN)
        LBAA_SET_LEVEL_ADDR:   set_level_r   <= WDATA_IN;  // [RQ6]
        LBAA_CLEAR_LEVEL_ADDR: clear_level_r <= WDATA_IN;  // [RQ6]
        LBAA_DECAY_RATE_ADDR:  decay_rate_r  <= WDATA_IN[LBAA_DECAY_MSB:LBAA_DECAY_LSB];
        default: ;
      endcase
    end
  end

  // Read data held until next read; unmapped reads return zero
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      RDATA_OUT <= 8'h00;
    end else if (RD_EN_IN) begin
      case (ADDR_IN)
        LBAA_SET_LEVEL_ADDR:   RDATA_OUT <= set_level_r;  // [RQ6]
        LBAA_CLEAR_LEVEL_ADDR: RDATA_OUT <= clear_level_r;  // [RQ6]
        LBAA_DECAY_RATE_ADDR:  RDATA_OUT <= {6'h00, decay_rate_r};
        default:               RDATA_OUT <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Fault capture within one observation cycle
  // ----------------------------------------------------------------------
  // A fault in the tick cycle itself counts toward the closing cycle
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      fault_seen_r <= 1'b0;
    end else if (tick) begin
      fault_seen_r <= 1'b0;
    end else if (FAULT_IN) begin
      fault_seen_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Bucket update
  // ----------------------------------------------------------------------
  always_comb begin
    clean_limit = decay_limit(decay_rate_r);
    bucket_nxt  = BUCKET_OUT;
    if (fault_seen_r || FAULT_IN) begin
      if (BUCKET_OUT != 8'hff) begin
        bucket_nxt = BUCKET_OUT + 8'h01;  // [RQ2]
      end
    end else if (clean_count_r == clean_limit && BUCKET_OUT != 8'h00) begin
      bucket_nxt = BUCKET_OUT - 8'h01;  // [RQ3] [RQ8]
    end
  end

  // Clean-period counter restarts on any faulty cycle
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      clean_count_r <= 3'h0;
    end else if (tick) begin
      if (fault_seen_r || FAULT_IN || clean_count_r >= clean_limit) begin
        clean_count_r <= 3'h0;  // [RQ3]
      end else begin
        clean_count_r <= clean_count_r + 3'h1;
      end
    end
  end

  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      BUCKET_OUT <= 8'h00;
    end else if (tick) begin
      BUCKET_OUT <= bucket_nxt;  // [RQ1]
    end
  end

  // ----------------------------------------------------------------------
  // Alarm with hysteresis
  // ----------------------------------------------------------------------
  always_comb begin
    alarm_nxt = ALARM_OUT;
    if (bucket_nxt >= set_level_r) begin
      alarm_nxt = 1'b1;  // [RQ4]
    end else if (bucket_nxt <= clear_level_r) begin
      alarm_nxt = 1'b0;  // [RQ5]
    end
  end

  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      ALARM_OUT <= 1'b0;
    end else if (tick) begin
      ALARM_OUT <= alarm_nxt;  // [RQ4] [RQ5]
    end
  end

endmodule : lbaa_top

// ### test/lbaa_monitor.sv
// Purpose: Port checker for lbaa_top
// Assumes: Levels mirrored from port writes
// Notes:   Timing bounds allow up to three clocks of slack
`timescale 1ns/1ps
module lbaa_monitor #(
  parameter int CYCLE_CLOCKS = 10
) (
  input wire logic       CLOCK_IN,
  input wire logic       RST_N_IN,
  input wire logic       FAULT_IN,
  input wire logic       WR_EN_IN,
  input wire logic       RD_EN_IN,
  input wire logic [7:0] ADDR_IN,
  input wire logic [7:0] WDATA_IN,
  input wire logic [7:0] RDATA_OUT,
  input wire logic       ALARM_OUT,
  input wire logic [7:0] BUCKET_OUT
);
  logic [7:0] set_r, clr_r, rexp;
  logic [1:0] dec_r;
  int         chg_r, flt_r;
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      set_r <= 8'h06; clr_r <= 8'h04; dec_r <= 2'h1; chg_r <= 0; flt_r <= 4095;
    end else begin
      if (WR_EN_IN && ADDR_IN == 8'h54) set_r <= WDATA_IN;
      if (WR_EN_IN && ADDR_IN == 8'h55) clr_r <= WDATA_IN;
      if (WR_EN_IN && ADDR_IN == 8'h57) dec_r <= WDATA_IN[1:0];
      chg_r <= $changed(BUCKET_OUT) ? 0 : chg_r + int'(chg_r < 4095);
      flt_r <= FAULT_IN ? 0 : flt_r + int'(flt_r < 4095);
    end
  end
  always_comb begin
    case (ADDR_IN)
      8'h54:   rexp = set_r;
      8'h55:   rexp = clr_r;
      8'h57:   rexp = {6'h00, dec_r};
      default: rexp = 8'h00;
    endcase
  end
  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (!RST_N_IN);
  sequence s_tick; $changed(BUCKET_OUT); endsequence
  property p_step; s_tick |-> BUCKET_OUT - $past(BUCKET_OUT) inside {8'h01, 8'hff}; endproperty
  property p_gap; s_tick |-> chg_r >= CYCLE_CLOCKS - 1; endproperty
  property p_inc; BUCKET_OUT == $past(BUCKET_OUT) + 8'h01 |-> flt_r <= CYCLE_CLOCKS + 2; endproperty
  property p_dec; BUCKET_OUT + 8'h01 == $past(BUCKET_OUT) |-> flt_r >= CYCLE_CLOCKS - 1; endproperty
  property p_on; s_tick and BUCKET_OUT >= set_r |-> ALARM_OUT; endproperty
  property p_off; s_tick and BUCKET_OUT < set_r && BUCKET_OUT <= clr_r |-> !ALARM_OUT; endproperty
  property p_read; RD_EN_IN |=> RDATA_OUT == $past(rexp); endproperty
  property p_hold; !RD_EN_IN |=> $stable(RDATA_OUT); endproperty
  a_step: assert property (p_step) else $error("bucket jumped");
  a_gap: assert property (p_gap) else $error("bucket changed early");
  a_inc: assert property (p_inc) else $error("rise with no fault");
  a_dec: assert property (p_dec) else $error("fall after fault");
  a_on: assert property (p_on) else $error("alarm not set");
  a_off: assert property (p_off) else $error("alarm not cleared");
  a_read: assert property (p_read) else $error("bad read data");
  a_hold: assert property (p_hold) else $error("read data moved");
endmodule : lbaa_monitor
bind lbaa_top lbaa_monitor #(.CYCLE_CLOCKS(CYCLE_CLOCKS)) u_mon (.CLOCK_IN(CLOCK_IN),
  .RST_N_IN(RST_N_IN), .FAULT_IN(FAULT_IN), .WR_EN_IN(WR_EN_IN), .RD_EN_IN(RD_EN_IN),
  .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .RDATA_OUT(RDATA_OUT), .ALARM_OUT(ALARM_OUT),
  .BUCKET_OUT(BUCKET_OUT));

// ### test/tb_lbaa_top.sv
// Purpose: Self-checking bench for lbaa_top
// Assumes: CYCLE_CLOCKS of 10
// Notes:   Faults pulse mid-cycle so no tick ambiguity
`timescale 1ns/1ps
module tb_lbaa_top;
  logic       CLOCK_IN = 0, RST_N_IN = 0, FAULT_IN = 0, WR_EN_IN = 0, RD_EN_IN = 0, ALARM_OUT;
  logic [7:0] ADDR_IN = 0, WDATA_IN = 0, RDATA_OUT, BUCKET_OUT, mb = 0, ms = 8'h06, ml = 8'h04;
  logic [31:0] seed = 32'h47;
  logic [1:0] mr = 2'h1;
  logic       ma = 0, f;
  int         miscompares = 0, checks_done = 0, cyc = 0, mc = 0;
  lbaa_top #(.CYCLE_CLOCKS(10)) dut (.CLOCK_IN(CLOCK_IN), .RST_N_IN(RST_N_IN),
    .FAULT_IN(FAULT_IN), .WR_EN_IN(WR_EN_IN), .RD_EN_IN(RD_EN_IN), .ADDR_IN(ADDR_IN),
    .WDATA_IN(WDATA_IN), .RDATA_OUT(RDATA_OUT), .ALARM_OUT(ALARM_OUT), .BUCKET_OUT(BUCKET_OUT));
  initial forever #5 CLOCK_IN = ~CLOCK_IN;
  // Hang guard, about twice the expected run
  always @(posedge CLOCK_IN) begin
    cyc++;
    if (cyc == 3000) begin miscompares++; conclude(); end
  end
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13; x ^= x >> 17; x ^= x << 5; return x;
  endfunction : xs
  function automatic void step(input logic flt);
    if (flt) begin mb += 8'(mb != 8'hff); mc = 0; end
    else if (++mc >= (1 << mr)) begin mc = 0; mb -= 8'(mb != 8'h00); end
    if (mb >= ms) ma = 1; else if (mb <= ml) ma = 0;
  endfunction : step
  task automatic chk(input logic [7:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin miscompares++; $display("unexpected at %0t: %h not %h", $time, seen, exp); end
  endtask : chk
  task automatic acc(input logic w, input logic [7:0] a, d);
    @(negedge CLOCK_IN); WR_EN_IN = w; RD_EN_IN = !w; ADDR_IN = a; WDATA_IN = d;
    @(negedge CLOCK_IN); WR_EN_IN = 0; RD_EN_IN = 0;
  endtask : acc
  // One observation cycle; optional write in mid-cycle
  task automatic period(input logic fl, w, input logic [7:0] a, d);
    repeat (4) @(negedge CLOCK_IN); FAULT_IN = fl;
    @(negedge CLOCK_IN); FAULT_IN = 0;
    chk(BUCKET_OUT, mb);
    chk({7'h00, ALARM_OUT}, {7'h00, ma});
    WR_EN_IN = w; ADDR_IN = a; WDATA_IN = d;
    @(negedge CLOCK_IN); WR_EN_IN = 0;
    if (w) case (a) 8'h54: ms = d; 8'h55: ml = d; default: mr = d[1:0]; endcase
    repeat (4) @(negedge CLOCK_IN); step(fl);
  endtask : period
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  initial begin
    repeat (8) @(negedge CLOCK_IN); RST_N_IN = 1;
    acc(0, 8'h54, 0); chk(RDATA_OUT, 8'h06);
    acc(0, 8'h55, 0); chk(RDATA_OUT, 8'h04);
    acc(0, 8'h57, 0); chk(RDATA_OUT, 8'h01);
    acc(1, 8'h54, seed[7:0]); acc(1, 8'h55, 8'h33); acc(1, 8'h57, 8'hfe);
    acc(0, 8'h54, 0); chk(RDATA_OUT, seed[7:0]);
    acc(0, 8'h55, 0); chk(RDATA_OUT, 8'h33);
    acc(0, 8'h57, 0); chk(RDATA_OUT, 8'h02);
    acc(0, 8'h56, 0); chk(RDATA_OUT, 8'h00);
    // Second reset must restore the defaults the model starts from
    @(negedge CLOCK_IN); RST_N_IN = 0; @(negedge CLOCK_IN); RST_N_IN = 1;
    for (int i = 0; i < 160; i++) begin
      seed = xs(seed);
      f = (i % 40 == 0) || (i % 40 < 14 && seed[1:0] != 2'h0);
      period(f, i % 40 < 3, i % 40 == 0 ? 8'h57 : i % 40 == 1 ? 8'h54 : 8'h55,
        i % 40 == 0 ? 8'(3 - i / 40) : i % 40 == 1 ? {5'h00, seed[6:4]} + 8'h04 : {5'h00, seed[10:8]});
    end
    conclude();
  end
endmodule : tb_lbaa_top
